// ---- hdl/tsr_defines.svh ----
// Overview of operation
// - writing trigger bit starts measurement, reads zero
// - in-progress flag high until measurement completes
// - result byte, one LSB per degree drop
// - gain boost defaults normal, high code boosts
// - amplifier setting one: default normal, boost code
// - amplifier setting two: default normal, boost code
// - fading gain control takes three codes
// - correction offset is register times 488 Hz
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define TSR_ADDR_TEMP_CTRL 7'h4e
`define TSR_ADDR_TEMP_RESULT 7'h4f
`define TSR_ADDR_RX_BOOST 7'h58
`define TSR_ADDR_HP_ONE 7'h5a
`define TSR_ADDR_HP_TWO 7'h5c
`define TSR_ADDR_FADING 7'h6f
`define TSR_ADDR_LOW_BETA 7'h71
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define TSR_BIT_TRIGGER 3
`define TSR_BIT_RUNNING 2
`define TSR_CTRL_LOW_BITS 2'h1
`define TSR_RX_BOOST_NORMAL 8'h1b
`define TSR_RX_BOOST_HIGH 8'h2d
`define TSR_HP_ONE_NORMAL 8'h55
`define TSR_HP_ONE_BOOST 8'h5d
`define TSR_HP_TWO_NORMAL 8'h70
`define TSR_HP_TWO_BOOST 8'h7c
`define TSR_FADING_NORMAL 8'h00
`define TSR_FADING_LB_ON 8'h20
`define TSR_FADING_LB_OFF 8'h30
`define TSR_LOW_BETA_RESET 8'h00
// ----------------------------------------
// timing and scaling
// ----------------------------------------
`define TSR_CLK_PERIOD_NS 10
`define TSR_MEAS_TIME_NS 1000
`define TSR_MEAS_CYCLES (`TSR_MEAS_TIME_NS / `TSR_CLK_PERIOD_NS)
`define TSR_OFFSET_STEP_HZ 488
`endif

// ---- hdl/tsr_pkg.sv ----
`default_nettype none
package tsr_pkg;
   typedef enum logic [1:0] {
      TSR_IDLE = 2'b00,
      TSR_CONVERT = 2'b01,
      TSR_DONE = 2'b10
   } tsr_state_t;
   typedef logic [7:0] tsr_byte_t;
endpackage
`default_nettype wire

// ---- hdl/tsr_converter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tsr_defines.svh"
module tsr_converter (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic start,
   input wire tsr_pkg::tsr_byte_t sensor_code,
   output logic busy,
   output tsr_pkg::tsr_byte_t result
);
   import tsr_pkg::*;
   tsr_state_t state_q, state_d;
   logic [15:0] cnt_q, cnt_d;
   tsr_byte_t result_q, result_d;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      result_d = result_q;
      case (state_q)
         TSR_IDLE: begin
            if (start) begin
               state_d = TSR_CONVERT;
               cnt_d = 16'(`TSR_MEAS_CYCLES - 1);
            end
         end
         TSR_CONVERT: begin
            if (cnt_q == 16'h0000) begin
               state_d = TSR_DONE;
            end else begin
               cnt_d = cnt_q - 16'h0001;
            end
         end
         TSR_DONE: begin
            // sensor gives one count per degree; result counts down as it warms
            result_d = ~sensor_code;
            state_d = TSR_IDLE;
         end
         default: state_d = TSR_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= TSR_IDLE;
         cnt_q <= 16'h0000;
         result_q <= 8'h00;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         result_q <= result_d;
      end
   end

   assign busy = (state_q != TSR_IDLE);
   assign result = result_q;
endmodule
`default_nettype wire

// ---- hdl/tsr_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tsr_defines.svh"
module tsr_regs (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wr_en,
   input wire logic [6:0] addr,
   input wire tsr_pkg::tsr_byte_t wdata,
   output tsr_pkg::tsr_byte_t rdata,
   input wire tsr_pkg::tsr_byte_t sensor_code,
   input wire logic low_index_correction_enable,
   output logic measurement_in_progress,
   output logic rx_blocked,
   output tsr_pkg::tsr_byte_t rx_gain_boost,
   output tsr_pkg::tsr_byte_t high_power_code_one,
   output tsr_pkg::tsr_byte_t high_power_code_two,
   output tsr_pkg::tsr_byte_t fading_gain_setting,
   output logic high_sensitivity,
   output logic boosted_output_20dbm,
   output logic signed [16:0] freq_correction_hz
);
   import tsr_pkg::*;

   // ----------------------------------------
   // tuning registers
   // ----------------------------------------
   tsr_byte_t boost_q, boost_d;
   tsr_byte_t hp1_q, hp1_d;
   tsr_byte_t hp2_q, hp2_d;
   tsr_byte_t fade_q, fade_d;
   tsr_byte_t lowb_q, lowb_d;
   tsr_byte_t rdata_q, rdata_d;
   logic start;
   logic busy;
   tsr_byte_t result;

   function automatic logic hit(input logic [6:0] a, input logic [6:0] target);
      hit = (a == target);
   endfunction

   function automatic logic fade_legal(input tsr_byte_t v);
      fade_legal = (v == `TSR_FADING_NORMAL) || (v == `TSR_FADING_LB_ON) ||
                   (v == `TSR_FADING_LB_OFF);
   endfunction

   always_comb begin
      boost_d = boost_q;
      hp1_d = hp1_q;
      hp2_d = hp2_q;
      fade_d = fade_q;
      lowb_d = lowb_q;
      if (wr_en) begin
         if (hit(addr, `TSR_ADDR_RX_BOOST)) begin
            boost_d = wdata;
         end
         if (hit(addr, `TSR_ADDR_HP_ONE)) begin
            hp1_d = wdata;
         end
         if (hit(addr, `TSR_ADDR_HP_TWO)) begin
            hp2_d = wdata;
         end
         // only the three defined codes are taken
         if (hit(addr, `TSR_ADDR_FADING) && fade_legal(wdata)) begin
            fade_d = wdata;
         end
         if (hit(addr, `TSR_ADDR_LOW_BETA)) begin
            lowb_d = wdata;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         boost_q <= `TSR_RX_BOOST_NORMAL;
         hp1_q <= `TSR_HP_ONE_NORMAL;
         hp2_q <= `TSR_HP_TWO_NORMAL;
         fade_q <= `TSR_FADING_LB_OFF;
         lowb_q <= `TSR_LOW_BETA_RESET;
      end else begin
         boost_q <= boost_d;
         hp1_q <= hp1_d;
         hp2_q <= hp2_d;
         fade_q <= fade_d;
         lowb_q <= lowb_d;
      end
   end

   // ----------------------------------------
   // temperature measurement
   // ----------------------------------------
   // a trigger while busy is ignored
   assign start = wr_en && hit(addr, `TSR_ADDR_TEMP_CTRL) && wdata[`TSR_BIT_TRIGGER] && !busy;

   tsr_converter tsr_converter_i (
      .clk(clk),
      .arst_n(arst_n),
      .start(start),
      .sensor_code(sensor_code),
      .busy(busy),
      .result(result)
   );

   // ----------------------------------------
   // read path
   // ----------------------------------------
   always_comb begin
      rdata_d = 8'h00;
      case (addr)
         `TSR_ADDR_TEMP_CTRL: begin
            // trigger bit always reads zero
            rdata_d = {4'h0, 1'b0, busy, `TSR_CTRL_LOW_BITS};
         end
         `TSR_ADDR_TEMP_RESULT: rdata_d = result;
         `TSR_ADDR_RX_BOOST: rdata_d = boost_q;
         `TSR_ADDR_HP_ONE: rdata_d = hp1_q;
         `TSR_ADDR_HP_TWO: rdata_d = hp2_q;
         `TSR_ADDR_FADING: rdata_d = fade_q;
         `TSR_ADDR_LOW_BETA: rdata_d = lowb_q;
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------
   // outputs to the radio
   // ----------------------------------------
   assign rdata = rdata_q;
   assign measurement_in_progress = busy;
   assign rx_blocked = busy;
   assign rx_gain_boost = boost_q;
   assign high_power_code_one = hp1_q;
   assign high_power_code_two = hp2_q;
   assign fading_gain_setting = fade_q;
   assign high_sensitivity = (boost_q == `TSR_RX_BOOST_HIGH);
   // boost needs both settings at their boost codes; host restores them for rx
   assign boosted_output_20dbm = (hp1_q == `TSR_HP_ONE_BOOST) && (hp2_q == `TSR_HP_TWO_BOOST);
   // offset register read as signed steps of 488 Hz, zero when disabled
   assign freq_correction_hz = low_index_correction_enable ?
      17'($signed(lowb_q) * $signed(17'(`TSR_OFFSET_STEP_HZ))) : 17'sh00000;
endmodule
`default_nettype wire

// ---- tb/tsr_regs_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsr_regs_properties (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wr_en,
   input wire logic [6:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic low_index_correction_enable,
   input wire logic measurement_in_progress,
   input wire logic rx_blocked,
   input wire logic [7:0] rx_gain_boost,
   input wire logic [7:0] high_power_code_one,
   input wire logic [7:0] high_power_code_two,
   input wire logic [7:0] fading_gain_setting,
   input wire logic high_sensitivity,
   input wire logic boosted_output_20dbm,
   input wire logic signed [16:0] freq_correction_hz
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   trig_start_a: assert property (wr_en && addr == 7'h4e && wdata[3] |=> measurement_in_progress)
      else $error("trigger did not start measurement");
   trig_reads_a: assert property (addr == 7'h4e |=> rdata[3] == 1'b0 && rdata[1:0] == 2'h1)
      else $error("control byte read wrong");
   busy_hold_a: assert property ($rose(measurement_in_progress) |-> measurement_in_progress[*8])
      else $error("flag dropped early");
   busy_end_a: assert property ($rose(measurement_in_progress) |-> ##[95:105] !measurement_in_progress)
      else $error("flag did not clear");
   rx_block_a: assert property (rx_blocked == measurement_in_progress)
      else $error("receiver block differs from flag");
   high_sens_a: assert property (high_sensitivity == (rx_gain_boost == 8'h2d))
      else $error("sensitivity select wrong");
   boost_sel_a: assert property (boosted_output_20dbm ==
      (high_power_code_one == 8'h5d && high_power_code_two == 8'h7c))
      else $error("boost select wrong");
   fading_keep_a: assert property (wr_en && addr == 7'h6f && !(wdata inside {8'h00, 8'h20, 8'h30})
      |=> $stable(fading_gain_setting))
      else $error("illegal fading code taken");
   corr_off_a: assert property (!low_index_correction_enable |-> freq_correction_hz == 17'sd0)
      else $error("correction applied while disabled");
endmodule
bind tsr_regs tsr_regs_properties tsr_regs_properties_i (.*);
`default_nettype wire

// ---- tb/tsr_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsr_host (
   input wire logic clk,
   output logic wr_en,
   output logic [6:0] addr,
   output tsr_pkg::tsr_byte_t wdata,
   input wire tsr_pkg::tsr_byte_t rdata
);
   import tsr_pkg::*;
   initial begin
      wr_en = 1'b0;
      addr = 7'h00;
      wdata = 8'h00;
   end
   task automatic wr(input logic [6:0] a, input tsr_byte_t d);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(posedge clk);
      #1 wr_en = 1'b0;
      wdata = ~d;
      // one idle edge, so a following write never re-raises the strobe in this time step
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [6:0] a, output tsr_byte_t d);
      addr = a;
      @(posedge clk);
      #1 d = rdata;
   endtask
   // back to normal codes before receiving
   task automatic rx_prep;
      wr(7'h5a, 8'h55);
      wr(7'h5c, 8'h70);
   endtask
endmodule
`default_nettype wire

// ---- tb/temp_sense_and_tuning_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module temp_sense_and_tuning_regs_tb;
   import tsr_pkg::*;
   logic clk = 1'b0, arst_n = 1'b0, en = 1'b0, wr_en, mip, rxb, hs, bo;
   logic [6:0] addr;
   tsr_byte_t wdata, rdata, b, h1, h2, fg, d, sc = 8'h3c;
   logic signed [16:0] fc;
   int fails = 0, compares = 0, n;
   logic [22:0] rows [10] = '{{7'h58, 8'h2d, 8'h2d}, {7'h58, 8'h1b, 8'h1b}, {7'h5a, 8'h5d, 8'h5d},
      {7'h5c, 8'h7c, 8'h7c}, {7'h6f, 8'h00, 8'h00}, {7'h6f, 8'h20, 8'h20}, {7'h6f, 8'h47, 8'h20},
      {7'h6f, 8'h30, 8'h30}, {7'h71, 8'h81, 8'h81}, {7'h60, 8'haa, 8'h00}};
   logic [14:0] rst [6] = '{{7'h4e, 8'h01}, {7'h58, 8'h1b}, {7'h5a, 8'h55}, {7'h5c, 8'h70},
      {7'h6f, 8'h30}, {7'h71, 8'h00}};
   always #5 clk = ~clk;
   tsr_host tsr_host_i (.clk(clk), .wr_en(wr_en), .addr(addr), .wdata(wdata), .rdata(rdata));
   tsr_regs tsr_regs_i (.clk(clk), .arst_n(arst_n), .wr_en(wr_en), .addr(addr), .wdata(wdata),
      .rdata(rdata), .sensor_code(sc), .low_index_correction_enable(en), .measurement_in_progress(mip),
      .rx_blocked(rxb), .rx_gain_boost(b), .high_power_code_one(h1), .high_power_code_two(h2),
      .fading_gain_setting(fg), .high_sensitivity(hs), .boosted_output_20dbm(bo), .freq_correction_hz(fc));
   task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      if (fails == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      #1 arst_n = 1'b1;
      foreach (rst[i]) begin
         tsr_host_i.rd(rst[i][14:8], d);
         chk(d, rst[i][7:0]);
      end
      foreach (rows[i]) begin
         tsr_host_i.wr(rows[i][22:16], rows[i][15:8]);
         tsr_host_i.rd(rows[i][22:16], d);
         chk(d, rows[i][7:0]);
      end
      chk(bo, 1'b1);
      chk(hs, 1'b0);
      tsr_host_i.rx_prep();
      chk(bo, 1'b0);
      chk(h1, 8'h55);
      chk(h2, 8'h70);
      chk(b, 8'h1b);
      chk(fg, 8'h30);
      tsr_host_i.wr(7'h4e, 8'h08);
      chk(mip, 1'b1);
      chk(rxb, 1'b1);
      tsr_host_i.wr(7'h4e, 8'h08);
      tsr_host_i.rd(7'h4e, d);
      chk(d, 8'h05);
      // host leaves the receiver alone until the flag clears
      for (n = 0; n < 300 && mip; n++) begin
         @(posedge clk);
         #1;
      end
      if (mip) begin
         fails++;
      end else begin
         tsr_host_i.rd(7'h4f, d);
         chk(d, 8'hc3);
         en = 1'b1;
         tsr_host_i.wr(7'h71, 8'h02);
         chk(fc, 17'sd976);
         tsr_host_i.wr(7'h71, 8'hff);
         chk(fc, -17'sd488);
         en = 1'b0;
         @(posedge clk);
         #1 chk(fc, 17'sd0);
         // reset in mid-measurement drops the flag and restores every register
         tsr_host_i.wr(7'h4e, 8'h08);
         arst_n = 1'b0;
         @(posedge clk);
         #1 chk(mip, 1'b0);
         arst_n = 1'b1;
         foreach (rst[i]) begin
            tsr_host_i.rd(rst[i][14:8], d);
            chk(d, rst[i][7:0]);
         end
         tsr_host_i.rd(7'h4f, d);
         chk(d, 8'h00);
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
